// >>> design/cfgpp_top.sv
// configuration packet processor: link sampler, packet decoder, registers, apb slave
`timescale 1ns/1ps
`default_nettype none
module cfgpp_top (
  input wire logic i_core_clk,             // 125 MHz core clock
  input wire logic i_rst_b,                // synchronous reset, active low
  input wire logic i_cfg_clk,              // config_clock pin from host
  input wire logic i_cfg_din,              // serial data pin
  input wire logic [7:0] i_cfg_d,          // byte-wide data pins, bit 0 is msb
  input wire logic i_psel,                 // apb select
  input wire logic i_penable,              // apb enable
  input wire logic i_pwrite,               // apb direction
  input wire logic [7:0] i_paddr,          // apb byte address
  input wire logic [31:0] i_pwdata,        // apb write data
  output logic [31:0] o_prdata,            // apb read data
  output logic o_pready,                   // apb ready
  output logic o_pslverr,                  // apb error, unmapped address
  output cfgpp_pkg::cfgpp_frame_s o_frame, // frame word and frame address
  output logic o_frame_we,                 // frame word strobe
  output logic [5:0] o_clk_sel,            // applied config clock selection
  output logic o_done,                     // completion flag
  output logic o_active,                   // device active
  output logic o_crc_err                   // crc check failed
);
  cfgpp_pkg::cfgpp_state_e state_r;
  logic [2:0] clk_sync_r;
  logic din_s1_r, din_s2_r;
  logic [7:0] d_s1_r, d_s2_r;
  logic cfg_rise;
  logic [31:0] shift_r;
  logic [31:0] shift_nxt;
  logic [5:0] bit_cnt_r;
  logic synced_r;
  logic word_vld_r;
  logic [31:0] word_r;
  logic [31:0] ctrl_r;
  logic [13:0] cur_addr_r;
  logic [1:0] cur_op_r;
  logic [26:0] cnt_r;
  logic wr_en;
  logic crc_cov;
  logic [15:0] crc_r, crc_nxt;
  logic [31:0] frame_len_r, opt_r, control_r, mask_r, far_r;
  logic [31:0] fword_r;
  logic [31:0] wcnt_r;
  logic write_frames_r, last_frame_r, start_r, hdr_err_r, crc_err_r;
  logic final_r;
  logic [4:0] edge_cnt_r;
  logic [31:0] rd_val;
  logic rd_hit;
  logic wr_status;

  // crc-16, x^16+x^15+x^2+1: 32 data bits then 4 address bits, lsb first
  function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [3:0] a,
                                           input logic [31:0] d);
    logic [35:0] v;
    logic [15:0] x;
    logic fb;
    v = {a, d};
    x = c;
    for (int i = 0; i < 36; i++) begin
      fb = v[i] ^ x[15];
      x = {x[14] ^ fb, x[13:2], x[1] ^ fb, x[0], fb};
    end
    return x;
  endfunction

  // pins pass two flops first; the clock gets a third for edge finding
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      clk_sync_r <= 3'h0;
      din_s1_r <= 1'b0;
      din_s2_r <= 1'b0;
      d_s1_r <= 8'h00;
      d_s2_r <= 8'h00;
    end else begin
      clk_sync_r <= {clk_sync_r[1:0], i_cfg_clk};
      din_s1_r <= i_cfg_din;
      din_s2_r <= din_s1_r;
      d_s1_r <= i_cfg_d;
      d_s2_r <= d_s1_r;
    end
  end
  assign cfg_rise = clk_sync_r[1] & ~clk_sync_r[2];

  // serial shifts one bit, byte mode shifts d0 in as msb
  always_comb begin
    if (ctrl_r[cfgpp_pkg::CTRL_BYTE]) begin
      shift_nxt = {shift_r[23:0], d_s2_r[0], d_s2_r[1], d_s2_r[2], d_s2_r[3], // R3
                   d_s2_r[4], d_s2_r[5], d_s2_r[6], d_s2_r[7]};
    end else begin
      shift_nxt = {shift_r[30:0], din_s2_r};
    end
  end

  // word framing: hunt for sync, then count 32 bits per word
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      shift_r <= 32'h0;
      bit_cnt_r <= 6'h0;
      synced_r <= 1'b0;
      word_vld_r <= 1'b0;
      word_r <= 32'h0;
    end else begin
      word_vld_r <= 1'b0;
      if (!ctrl_r[cfgpp_pkg::CTRL_EN]) begin
        synced_r <= 1'b0;
        bit_cnt_r <= 6'h0;
      end else if (cfg_rise) begin
        shift_r <= shift_nxt;
        if (!synced_r) begin
          // stream content before the sync word is dropped unseen
          if (shift_nxt == cfgpp_pkg::SYNC_WORD) begin // R1
            synced_r <= 1'b1;
            bit_cnt_r <= 6'h0; // R2
          end
        end else if (bit_cnt_r + (ctrl_r[cfgpp_pkg::CTRL_BYTE] ? 6'h08 : 6'h01)
                     == 6'h20) begin // R2
          bit_cnt_r <= 6'h0;
          word_vld_r <= 1'b1;
          word_r <= shift_nxt;
        end else begin
          bit_cnt_r <= bit_cnt_r + (ctrl_r[cfgpp_pkg::CTRL_BYTE] ? 6'h08 : 6'h01);
        end
      end
    end
  end

  // packet decoder; read packets are taken as carrying no inbound data
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      state_r <= cfgpp_pkg::S_HUNT;
      cur_addr_r <= 14'h0;
      cur_op_r <= 2'h0;
      cnt_r <= 27'h0;
      hdr_err_r <= 1'b0;
    end else begin
      if (wr_status && i_pwdata[cfgpp_pkg::ST_HDRERR]) begin
        hdr_err_r <= 1'b0;
      end
      if (!synced_r) begin
        state_r <= cfgpp_pkg::S_HUNT; // R1
      end else begin
        unique case (state_r)
          cfgpp_pkg::S_HUNT: begin
            state_r <= cfgpp_pkg::S_HDR;
          end
          cfgpp_pkg::S_HDR: begin
            if (word_vld_r) begin
              if (word_r[31:29] == cfgpp_pkg::TYPE1) begin // R5
                cur_op_r <= word_r[28:27];
                cur_addr_r <= word_r[26:13];
                cnt_r <= {16'h0, word_r[10:0]}; // R6
                if (word_r[28:27] == cfgpp_pkg::OP_WRITE && word_r[10:0] != 11'h0) begin
                  state_r <= cfgpp_pkg::S_DATA;
                end
              end else if (word_r[31:29] == cfgpp_pkg::TYPE2) begin // R7
                // address kept from the preceding type 1 header
                cur_op_r <= word_r[28:27]; // R27
                cnt_r <= word_r[26:0]; // R9
                if (word_r[28:27] == cfgpp_pkg::OP_WRITE && word_r[26:0] != 27'h0) begin
                  state_r <= cfgpp_pkg::S_DATA;
                end
              end else begin
                hdr_err_r <= 1'b1; // R28
              end
            end
          end
          cfgpp_pkg::S_DATA: begin
            if (word_vld_r) begin
              cnt_r <= cnt_r - 27'h1;
              if (cnt_r == 27'h1) begin
                state_r <= cfgpp_pkg::S_HDR;
              end
            end
          end
          default: begin
            state_r <= cfgpp_pkg::S_HUNT;
          end
        endcase
      end
    end
  end

  assign wr_en = (state_r == cfgpp_pkg::S_DATA) && word_vld_r && synced_r
                 && (cur_op_r == cfgpp_pkg::OP_WRITE);
  assign crc_cov = (cur_addr_r[13:4] == 10'h0) && (cur_addr_r[3:0] != 4'h3)
                   && (cur_addr_r[3:0] != 4'h8);
  assign crc_nxt = crc_word(crc_r, cur_addr_r[3:0], word_r); // R25

  // crc accumulator; a reset command clears it instead of feeding its own word
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      crc_r <= 16'h0;
      crc_err_r <= 1'b0;
    end else begin
      if (wr_status && i_pwdata[cfgpp_pkg::ST_CRCERR]) begin
        crc_err_r <= 1'b0;
      end
      if (wr_en && crc_cov) begin
        if (cur_addr_r == cfgpp_pkg::RA_CMD && word_r == cfgpp_pkg::CMD_CRC_RESET) begin
          crc_r <= 16'h0; // R10
        end else begin
          crc_r <= crc_nxt; // R25
        end
        if (cur_addr_r == cfgpp_pkg::RA_CRC && crc_nxt != 16'h0) begin
          crc_err_r <= 1'b1; // R26
        end
      end
    end
  end

  // configuration registers and command effects
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      frame_len_r <= 32'h0;
      opt_r <= 32'h0;
      control_r <= 32'h0;
      mask_r <= 32'h0;
      write_frames_r <= 1'b0;
      last_frame_r <= 1'b0;
      start_r <= 1'b0;
      o_clk_sel <= 6'h0;
    end else if (wr_en) begin
      unique case (cur_addr_r) // R23
        cfgpp_pkg::RA_FRAME_LEN: frame_len_r <= word_r; // R11
        cfgpp_pkg::RA_OPT: opt_r <= word_r; // R11
        cfgpp_pkg::RA_MASK: mask_r <= word_r; // R11
        cfgpp_pkg::RA_CONTROL: control_r <= (control_r & ~mask_r) | (word_r & mask_r); // R24
        cfgpp_pkg::RA_CMD: begin
          if (word_r == cfgpp_pkg::CMD_SWITCH) begin
            o_clk_sel <= opt_r[cfgpp_pkg::OPT_CLK_LSB +: cfgpp_pkg::OPT_CLK_W]; // R13
          end
          if (word_r == cfgpp_pkg::CMD_WRITE_FRAMES) begin
            write_frames_r <= 1'b1; // R14
          end
          if (word_r == cfgpp_pkg::CMD_LAST_FRAME) begin
            last_frame_r <= 1'b1; // R19
          end
          if (word_r == cfgpp_pkg::CMD_START) begin
            start_r <= 1'b1; // R20
          end
        end
        default: begin
        end
      endcase
    end
  end

  // frame path: address steps after each frame of length register + 1 words
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      far_r <= 32'h0;
      fword_r <= 32'h0;
      wcnt_r <= 32'h0;
      o_frame <= '0;
      o_frame_we <= 1'b0;
    end else begin
      o_frame_we <= 1'b0;
      if (wr_en && cur_addr_r == cfgpp_pkg::RA_FAR) begin
        far_r <= word_r;
        fword_r <= 32'h0;
      end else if (wr_en && cur_addr_r == cfgpp_pkg::RA_FRAME_DATA && write_frames_r) begin // R14 R17
        o_frame <= '{addr: far_r, data: word_r};
        o_frame_we <= 1'b1;
        wcnt_r <= wcnt_r + 32'h1;
        if (fword_r >= frame_len_r) begin
          fword_r <= 32'h0;
          far_r <= far_r + 32'h1;
        end else begin
          fword_r <= fword_r + 32'h1;
        end
      end
    end
  end

  // start-up: count config clock edges once the final crc is in and good
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      final_r <= 1'b0;
      edge_cnt_r <= 5'h0;
      o_done <= 1'b0;
      o_active <= 1'b0;
    end else begin
      // flags are registered so the pins never glitch while the counter steps
      o_done <= final_r && (edge_cnt_r >= cfgpp_pkg::DONE_EDGES); // R21
      o_active <= final_r && (edge_cnt_r >= cfgpp_pkg::ACTIVE_EDGES); // R20 R21
      if (wr_en && start_r && cur_addr_r == cfgpp_pkg::RA_CRC && crc_nxt == 16'h0) begin
        final_r <= 1'b1; // R20
      end
      // clocks stop counting at the end; host padding may keep coming
      if (final_r && cfg_rise && edge_cnt_r != cfgpp_pkg::END_EDGES) begin
        edge_cnt_r <= edge_cnt_r + 5'h1; // R21
      end
    end
  end
  assign o_crc_err = crc_err_r;

  // apb read mux
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0;
    unique case (i_paddr)
      cfgpp_pkg::OFS_CTRL: rd_val = ctrl_r;
      cfgpp_pkg::OFS_STATUS: rd_val = {24'h0, start_r, last_frame_r, write_frames_r, hdr_err_r,
                                       crc_err_r, o_active, o_done, synced_r};
      cfgpp_pkg::OFS_FRAME_LEN: rd_val = frame_len_r;
      cfgpp_pkg::OFS_OPT: rd_val = opt_r;
      cfgpp_pkg::OFS_CONTROL: rd_val = control_r;
      cfgpp_pkg::OFS_MASK: rd_val = mask_r;
      cfgpp_pkg::OFS_FAR: rd_val = far_r;
      cfgpp_pkg::OFS_CRC: rd_val = {16'h0, crc_r};
      cfgpp_pkg::OFS_WCNT: rd_val = wcnt_r;
      default: rd_hit = 1'b0;
    endcase
  end

  // zero wait states; read data is caught in the setup cycle
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !rd_hit;
  assign wr_status = i_psel && i_penable && i_pwrite && (i_paddr == cfgpp_pkg::OFS_STATUS);

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_prdata <= 32'h0;
      ctrl_r <= cfgpp_pkg::CTRL_RST;
    end else begin
      if (i_psel && !i_penable && !i_pwrite) begin
        o_prdata <= rd_val;
      end
      if (i_psel && i_penable && i_pwrite && i_paddr == cfgpp_pkg::OFS_CTRL) begin
        ctrl_r <= {30'h0, i_pwdata[1:0]};
      end
    end
  end
endmodule // cfgpp_top
`default_nettype wire

// >>> design/cfgpp_pkg.sv
// constants, types and register map of the configuration packet processor
// What the document requires
// R1: ignore the stream until the sync word AA995566h is seen
// R2: bit after the sync word starts a new 32-bit word, serial or byte-wide
// R3: data line zero carries the most significant bit of each byte
// R4: host pads the stream front with all-ones words before sync
// R5: type 1 header: type 31:29=001, op 28:27, address 26:13, byte 12:11, count 10:0
// R6: type 1 packet carries 0 to 2047 data words to the addressed register
// R7: type 2 header: type 010, op 28:27, count 26:0, no address fields
// R8: host puts a zero-count type 1 header before every type 2 header
// R9: type 2 packet bodies carry up to 1048575 words
// R10: command write header 30008001h; data 7 resets the crc accumulator
// R11: frame length, option and mask writes use headers 30016001h, 30012001h, 3000C001h
// R12: host loads frame length as frame bits divided by 32 minus one
// R13: clock-switch code 9 applies the clock selection held in the option register
// R14: write-frames code 1 lets frame data input words reach configuration memory
// R15: host writes frame address zero first, header 30002001h
// R16: host sends frame address, zero-count type 1 to frame data, type 2, then words
// R17: frame data may come as type 1 alone or type 1 plus type 2
// R18: host writes an intermediate crc with header 30000001h before the last frame
// R19: last frame follows last-frame code 3, with no frame address write
// R20: device goes active only after start, control write and final crc load; the code does not wait for the control write
// R21: completion 8 to 16 clocks after final crc; done flag within seven
// R22: host clocks trailing zero padding words after the final crc
// R23: register codes crc=0 address=1 data=2 command=4 control=5 mask=6 option=9 length=11
// R24: control register bits change only where the mask bit is set
// R25: each covered write feeds data then address code, lsb first, into crc-16
// R26: after a crc value write the accumulator must be zero, else crc error
// R27: type 2 words go to the register and direction of the preceding type 1; the code takes the direction from the type 2 header
// R28: unknown header type is discarded and flagged as an error
package cfgpp_pkg;
  // stream constants
  localparam logic [31:0] SYNC_WORD = 32'hAA995566;
  localparam logic [2:0] TYPE1 = 3'h1;
  localparam logic [2:0] TYPE2 = 3'h2;
  localparam logic [1:0] OP_WRITE = 2'h2;
  localparam logic [1:0] OP_READ = 2'h1;
  // register address codes
  localparam logic [13:0] RA_CRC = 14'h0000;
  localparam logic [13:0] RA_FAR = 14'h0001;
  localparam logic [13:0] RA_FRAME_DATA = 14'h0002;
  localparam logic [13:0] RA_CMD = 14'h0004;
  localparam logic [13:0] RA_CONTROL = 14'h0005;
  localparam logic [13:0] RA_MASK = 14'h0006;
  localparam logic [13:0] RA_OPT = 14'h0009;
  localparam logic [13:0] RA_FRAME_LEN = 14'h000B;
  // command codes
  localparam logic [31:0] CMD_WRITE_FRAMES = 32'h00000001;
  localparam logic [31:0] CMD_LAST_FRAME = 32'h00000003;
  localparam logic [31:0] CMD_START = 32'h00000005;
  localparam logic [31:0] CMD_CRC_RESET = 32'h00000007;
  localparam logic [31:0] CMD_SWITCH = 32'h00000009;
  // option register clock selection field
  localparam int OPT_CLK_LSB = 0;
  localparam int OPT_CLK_W = 6;
  // completion timing in config clock edges after final crc
  localparam logic [4:0] DONE_EDGES = 5'h07;
  localparam logic [4:0] ACTIVE_EDGES = 5'h08;
  localparam logic [4:0] END_EDGES = 5'h10;
  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FRAME_LEN = 8'h08;
  localparam logic [7:0] OFS_OPT = 8'h0C;
  localparam logic [7:0] OFS_CONTROL = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_FAR = 8'h18;
  localparam logic [7:0] OFS_CRC = 8'h1C;
  localparam logic [7:0] OFS_WCNT = 8'h20;
  // control register fields and reset
  localparam int CTRL_EN = 0;
  localparam int CTRL_BYTE = 1;
  localparam logic [31:0] CTRL_RST = 32'h00000001;
  // status bit positions
  localparam int ST_SYNC = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ACTIVE = 2;
  localparam int ST_CRCERR = 3;
  localparam int ST_HDRERR = 4;
  localparam int ST_WRITE_FRAMES = 5;
  localparam int ST_LAST_FRAME = 6;
  localparam int ST_START = 7;

  typedef enum logic [2:0] {
    S_HUNT = 3'b001,
    S_HDR = 3'b010,
    S_DATA = 3'b100
  } cfgpp_state_e;

  // one frame word headed for configuration memory
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } cfgpp_frame_s;
endpackage : cfgpp_pkg

// >>> tb/cfgpp_top_properties.sv
// port assertions for the configuration packet processor
`timescale 1ns/1ps
`default_nettype none
module cfgpp_top_properties (
  input wire logic i_core_clk, // core clock
  input wire logic i_rst_b, // sync reset
  input wire logic i_cfg_clk, // link clock pin
  input wire logic i_psel, // apb select
  input wire logic i_penable, // apb enable
  input wire logic i_pwrite, // apb direction
  input wire logic [7:0] i_paddr, // apb address
  input wire logic [31:0] i_pwdata, // apb write data
  input wire logic [31:0] o_prdata, // apb read data
  input wire logic o_pready, // apb ready
  input wire logic o_pslverr, // apb error
  input wire cfgpp_pkg::cfgpp_frame_s o_frame, // frame word
  input wire logic o_frame_we, // frame strobe
  input wire logic [5:0] o_clk_sel, // clock selection
  input wire logic o_done, // completion
  input wire logic o_active, // active
  input wire logic o_crc_err // crc failure
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // software clear of the sticky crc flag is the only way out
  wire logic crc_clear = i_psel && i_penable && i_pwrite && (i_paddr == 8'h04) && i_pwdata[3];
  // bus answers without wait states
  chk_zero_wait: assert property (i_psel && i_penable |-> o_pready)
    else $error("ready missing in access");
  chk_err_access: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("error outside access");
  chk_err_rdata: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h00000000)
    else $error("error read not zero");
  // frame strobes follow link edges, one cycle each, and data stands between them
  chk_strobe_pulse: assert property (o_frame_we |=> !o_frame_we)
    else $error("frame strobe too long");
  chk_frame_holds: assert property ($changed(o_frame) |-> o_frame_we)
    else $error("frame moved without strobe");
  chk_frame_on_link: assert property (o_frame_we |-> $past(i_cfg_clk, 3))
    else $error("frame strobe without link edge");
  chk_sel_on_link: assert property ($changed(o_clk_sel) |-> $past(i_cfg_clk, 3))
    else $error("clock select moved without link edge");
  // start-up order: done leads active by a link period
  chk_done_first: assert property (o_active |-> o_done)
    else $error("active without done");
  chk_done_lead: assert property ($rose(o_active) |-> $past(o_done, 8))
    else $error("active too soon after done");
  chk_crc_sticky: assert property (o_crc_err && !crc_clear |=> o_crc_err)
    else $error("crc error dropped");
  cover property (o_frame_we);
  cover property ($rose(o_active));
  cover property ($rose(o_crc_err));
endmodule // cfgpp_top_properties
bind cfgpp_top cfgpp_top_properties u_props (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
  .i_cfg_clk(i_cfg_clk), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_frame(o_frame), .o_frame_we(o_frame_we), .o_clk_sel(o_clk_sel),
  .o_done(o_done), .o_active(o_active), .o_crc_err(o_crc_err));
`default_nettype wire

// >>> tb/cfgpp_host.sv
// configuration host model driving the link clock and data pins
`timescale 1ns/1ps
`default_nettype none
module cfgpp_host (
  output logic o_cfg_clk, // link clock, low between transfers
  output logic o_cfg_din, // serial data
  output logic [7:0] o_cfg_d // byte data, bit 0 most significant
);
  initial begin
    o_cfg_clk = 1'b0;
    o_cfg_din = 1'b0;
    o_cfg_d = 8'h00;
  end
  // one 160 ns link period; the 43 ns offset keeps link edges off core edges
  task automatic pulse(input logic b, input logic [7:0] by);
    o_cfg_din = b;
    o_cfg_d = by;
    #43 o_cfg_clk = 1'b1;
    #80 o_cfg_clk = 1'b0;
    #37;
    // hold time over: show the inverse, never a stale value
    o_cfg_din = ~b;
    o_cfg_d = ~by;
  endtask
  // msb first; byte mode sends the most significant byte first
  task automatic send_word(input logic [31:0] w, input logic byte_mode);
    logic [7:0] by;
    if (!byte_mode) begin
      for (int i = 31; i >= 0; i--) begin
        pulse(w[i], 8'h00);
      end
    end else begin
      for (int k = 3; k >= 0; k--) begin
        for (int j = 0; j < 8; j++) begin
          by[j] = w[8*k+7-j];
        end
        pulse(1'b0, by);
      end
    end
  endtask
endmodule // cfgpp_host
`default_nettype wire

// >>> tb/cfgpp_top_test.sv
// self-checking bench: serial and byte-wide configuration streams
`timescale 1ns/1ps
`default_nettype none
module cfgpp_top_test;
  logic clk = 1'b0;
  logic rst_b, psel, penable, pwrite, byte_mode, err_v;
  logic [7:0] paddr;
  logic [15:0] crc_acc;
  logic [31:0] pwdata, rdata_v, opt_v, far_v, cnt;
  wire logic cfg_clk, cfg_din, pready, pslverr, frame_we, done, active, crc_err;
  wire logic [7:0] cfg_d;
  wire logic [5:0] clk_sel;
  wire logic [31:0] prdata;
  wire cfgpp_pkg::cfgpp_frame_s frame;
  cfgpp_pkg::cfgpp_frame_s exp_q[$];
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  integer seed = 32'hc6f7;
  always #4 clk = ~clk;
  cfgpp_host u_host (.o_cfg_clk(cfg_clk), .o_cfg_din(cfg_din), .o_cfg_d(cfg_d));
  cfgpp_top u_dut (.i_core_clk(clk), .i_rst_b(rst_b), .i_cfg_clk(cfg_clk), .i_cfg_din(cfg_din),
    .i_cfg_d(cfg_d), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_frame(frame), .o_frame_we(frame_we), .o_clk_sel(clk_sel), .o_done(done),
    .o_active(active), .o_crc_err(crc_err));
  task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_frame(input cfgpp_pkg::cfgpp_frame_s exp, input cfgpp_pkg::cfgpp_frame_s got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected frame: expected %h seen %h", exp, got);
    end
  endtask
  // apb transfer; holds the request until ready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no local limit: a hang is caught by the cycle ceiling
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdata_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic apb_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h00000000);
    cmp_val(what, exp, rdata_v);
  endtask
  // crc-16 model, x16+x15+x2+1: data then address code, lsb first
  function automatic logic [15:0] crc_feed(input logic [15:0] c, input logic [31:0] dw,
                                           input logic [3:0] a);
    logic [35:0] s;
    logic fb;
    s = {a, dw};
    for (int i = 0; i < 36; i++) begin
      fb = s[i] ^ c[15];
      c = {c[14] ^ fb, c[13:2], c[1] ^ fb, c[0], fb};
    end
    return c;
  endfunction
  // search for the check word that leaves the accumulator at zero
  function automatic logic [31:0] crc_fix(input logic [15:0] c);
    for (int v = 0; v < 65536; v++) begin
      if (crc_feed(c, 32'(v), 4'h0) == 16'h0000) return 32'(v);
    end
    return 32'h00000000;
  endfunction
  task automatic word(input logic [31:0] w);
    u_host.send_word(w, byte_mode);
  endtask
  task automatic reg_wr(input logic [31:0] hdr, input logic [31:0] dw);
    word(hdr);
    word(dw);
    crc_acc = crc_feed(crc_acc, dw, hdr[16:13]);
  endtask
  // random frame word; expectation noted before it is sent
  task automatic frame_wr(input logic [31:0] addr);
    logic [31:0] dw;
    dw = $random(seed);
    exp_q.push_back({addr, dw});
    word(dw);
    crc_acc = crc_feed(crc_acc, dw, 4'h2);
  endtask
  // oldest noted frame is compared against every strobe
  always @(posedge clk) begin
    if (frame_we === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("unexpected frame: expected none seen %h", frame);
      end else begin
        cmp_frame(exp_q.pop_front(), frame);
      end
    end
  end
  task automatic tally_and_finish();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // both streams need about 28000 to 30000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("unexpected timeout: expected end seen cycle %0d", cycles);
      tally_and_finish();
    end
  end
  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    byte_mode = 1'b0;
    crc_acc = 16'h0000;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    apb_chk(cfgpp_pkg::OFS_CTRL, cfgpp_pkg::CTRL_RST, "ctrl reset");
    apb(1'b0, 8'h40, 32'h00000000);
    cmp_val("unmapped read", 32'h00000000, rdata_v);
    cmp_val("unmapped error", 32'h00000001, {31'h0, err_v});
    // serial stream; a decoy command ahead of sync must be ignored
    word(32'hFFFFFFFF);
    word(32'hFFFFFFFF);
    word(32'h30008001);
    word(cfgpp_pkg::CMD_LAST_FRAME);
    apb_chk(cfgpp_pkg::OFS_STATUS, 32'h00000000, "status before sync");
    word(cfgpp_pkg::SYNC_WORD);
    reg_wr(32'h30008001, cfgpp_pkg::CMD_CRC_RESET);
    crc_acc = 16'h0000;
    opt_v = $random(seed);
    reg_wr(32'h30016001, 32'h00000014);
    reg_wr(32'h30012001, opt_v);
    reg_wr(32'h3000C001, 32'h00000000);
    reg_wr(32'h30008001, cfgpp_pkg::CMD_SWITCH);
    cmp_val("clock select", {26'h0, opt_v[5:0]}, {26'h0, clk_sel});
    reg_wr(32'h30008001, cfgpp_pkg::CMD_WRITE_FRAMES);
    reg_wr(32'h30002001, 32'h00000000);
    word(32'h30004000);
    cnt = 32'h2 + ($random(seed) & 32'h3);
    word(32'h50000000 | cnt);
    for (int i = 0; i < cnt; i++) begin
      frame_wr(32'h00000000);
    end
    word(32'hE0000000);
    apb_chk(cfgpp_pkg::OFS_STATUS, 32'h00000031, "status mid stream");
    apb_chk(cfgpp_pkg::OFS_FRAME_LEN, 32'h00000014, "frame length");
    apb_chk(cfgpp_pkg::OFS_OPT, opt_v, "options");
    reg_wr(32'h30000001, crc_fix(crc_acc));
    reg_wr(32'h30008001, cfgpp_pkg::CMD_LAST_FRAME);
    word(32'h30004001);
    frame_wr(32'h00000000);
    reg_wr(32'h30008001, cfgpp_pkg::CMD_START);
    reg_wr(32'h3000C001, 32'h0000000F);
    reg_wr(32'h3000A001, 32'hFFFFFFFF);
    reg_wr(32'h30000001, crc_fix(crc_acc));
    cmp_val("done at final crc", 32'h0, {31'h0, done});
    for (int i = 1; i <= 8; i++) begin
      u_host.pulse(1'b0, 8'h00);
      cmp_val("done", {31'h0, i >= 7}, {31'h0, done});
      cmp_val("active", {31'h0, i >= 8}, {31'h0, active});
    end
    repeat (4) word(32'h00000000);
    apb_chk(cfgpp_pkg::OFS_STATUS, 32'h000000F7, "status after start");
    apb_chk(cfgpp_pkg::OFS_CONTROL, 32'h0000000F, "masked control");
    cmp_val("crc error", 32'h0, {31'h0, crc_err});
    $display("test serial stream done");
    // byte-wide stream after dropping sync; a wrong check word must be caught
    apb(1'b1, cfgpp_pkg::OFS_CTRL, 32'h00000000);
    apb(1'b1, cfgpp_pkg::OFS_CTRL, 32'h00000003);
    byte_mode = 1'b1;
    far_v = $random(seed);
    word(32'hFFFFFFFF);
    word(cfgpp_pkg::SYNC_WORD);
    reg_wr(32'h30008001, cfgpp_pkg::CMD_CRC_RESET);
    crc_acc = 16'h0000;
    reg_wr(32'h30008001, cfgpp_pkg::CMD_WRITE_FRAMES);
    reg_wr(32'h30002001, far_v);
    word(32'h30004002);
    frame_wr(far_v);
    frame_wr(far_v);
    reg_wr(32'h30000001, crc_fix(crc_acc) ^ 32'h00000001);
    cmp_val("crc error", 32'h1, {31'h0, crc_err});
    // write one to clear; the flag drops at the access edge, so look an edge later
    apb(1'b1, cfgpp_pkg::OFS_STATUS, 32'h00000008);
    @(posedge clk);
    cmp_val("crc error cleared", 32'h0, {31'h0, crc_err});
    cmp_val("pending frames", 32'h0, 32'(exp_q.size()));
    $display("test byte stream done");
    tally_and_finish();
  end
endmodule // cfgpp_top_test
`default_nettype wire
